// *** hdl/sipm_pkg.sv ***
// constants and carrier types for the sync input phase monitor
package sipm_pkg;
  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [7:0] SIPM_ADDR_PHASE = 8'h7b;
  localparam logic [7:0] SIPM_ADDR_MON   = 8'h7c;
  localparam logic [7:0] SIPM_PHASE_RST  = 8'h00;
  localparam logic [7:0] SIPM_MON_RST    = 8'h2b;
  // field positions
  localparam int SIPM_PH_INDEP_POS = 7;
  localparam int SIPM_PH_LINE_POS  = 6;
  localparam int SIPM_PH_PHASE_LSB = 0;
  localparam int SIPM_MON_CAL_POS  = 7;
  localparam int SIPM_MON_LIM_LSB  = 4;
  localparam int SIPM_MON_SRC_LSB  = 0;
  // sampling phase codes
  localparam logic [1:0] SIPM_PHASE_ON_TARGET = 2'h0;
  localparam logic [1:0] SIPM_PHASE_HALF_EARLY = 2'h1;
  localparam logic [1:0] SIPM_PHASE_ONE_LATE  = 2'h2;
  localparam logic [1:0] SIPM_PHASE_HALF_LATE = 2'h3;
  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int SIPM_CLK_PERIOD_NS  = 100;
  localparam int SIPM_RAMP_STEP_NS   = 1000;
  localparam int SIPM_RAMP_STEP_CYC  = (SIPM_RAMP_STEP_NS + SIPM_CLK_PERIOD_NS - 1)
                                       / SIPM_CLK_PERIOD_NS;
  localparam int SIPM_FRAME_NS       = 125000;
  localparam int SIPM_FRAME_CYC      = SIPM_FRAME_NS / SIPM_CLK_PERIOD_NS;
  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       independent_frame_pulses;
    logic       line_rate_sync_sampling;
    logic [1:0] sync_phase;
  } sipm_phase_cfg_t;

  typedef struct packed {
    logic [2:0] limit;
    logic [3:0] ref_source;
  } sipm_mon_cfg_t;

  typedef enum {
    SIPM_CAL_IDLE,
    SIPM_CAL_TO_ZERO,
    SIPM_CAL_DIV_RST,
    SIPM_CAL_TO_PROG
  } sipm_cal_state_t;
endpackage

// *** hdl/sipm_align_check.sv ***
// alignment checker between the external sync edge and the output frame mark
`timescale 1ns/1ps
module sipm_align_check
  import sipm_pkg::*;
#(
  parameter int FRAME_LEN = SIPM_FRAME_CYC
) (
  input  wire logic               i_clk,
  input  wire logic               i_rstn,
  input  wire logic               i_frame_mark,
  input  wire logic               i_sync_edge,
  input  wire logic [1:0]         i_sync_phase,
  input  wire logic [2:0]         i_limit,
  output logic                    o_alarm,
  output logic signed [14:0]      o_error
);
  logic        [12:0] cnt;
  logic        [12:0] next_cnt;
  logic               next_alarm;
  logic signed [14:0] next_error;
  logic signed [14:0] dist2;
  logic signed [14:0] shift2;
  logic signed [14:0] comp;
  logic signed [14:0] mag;
  logic signed [14:0] win2;

  // distance to nearest frame mark in half unit intervals, shifted by phase
  always_comb begin
    next_cnt = i_frame_mark ? 13'h0000 : ((cnt == 13'h1fff) ? cnt : cnt + 13'h0001);
    if (32'(cnt) < FRAME_LEN / 2) begin
      dist2 = 15'(cnt) <<< 1;
    end else begin
      dist2 = (15'(cnt) - 15'(FRAME_LEN)) <<< 1;
    end
    unique case (i_sync_phase)
      SIPM_PHASE_ON_TARGET:  shift2 = 15'sh0000;
      SIPM_PHASE_HALF_EARLY: shift2 = -15'sh0001;
      SIPM_PHASE_ONE_LATE:   shift2 = 15'sh0002;
      SIPM_PHASE_HALF_LATE:  shift2 = 15'sh0001;
    endcase
    comp       = dist2 - shift2;
    mag        = comp[14] ? -comp : comp;
    win2       = 15'({i_limit, 1'b0}) + 15'sh0002;
    next_error = i_sync_edge ? comp : o_error;
    next_alarm = i_sync_edge ? (mag > win2) : o_alarm;
  end

  // state registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt     <= 13'h0000;
      o_alarm <= 1'b0;
      o_error <= 15'sh0000;
    end else begin
      cnt     <= next_cnt;
      o_alarm <= next_alarm;
      o_error <= next_error;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  alarm_window_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_sync_edge |=> o_alarm == ($past(mag) > $past(win2)))
    else $error("alarm does not follow window");
  alarm_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !i_sync_edge |=> $stable(o_alarm))
    else $error("alarm changed without sync edge");
  cover_alarm_c: cover property (@(posedge i_clk) disable iff (!i_rstn) $rose(o_alarm));
endmodule

// *** hdl/sipm_top.sv ***
// sync input phase monitor: registers, sync sampling, ramping and calibration
`timescale 1ns/1ps
// Functional notes
// - with the calibrate bit at 0 the applied offset walks gradually to each new value.
// - writing 1 to the calibrate bit launches the internal phase-offset calibration routine.
// - the calibrate bit returns to 0 by itself once calibration ends so software can poll it.
// - calibration holds over, ramps to zero, resets dividers, ramps back, leaves holdover.
// - the three-bit limit sets an alarm window of plus or minus one to eight reference cycles.
// - the monitor checks the sync input against the generated output instead of realigning to it.
// - a sync edge outside the programmed window raises the sync alarm.
module sipm_top
  import sipm_pkg::*;
#(
  parameter int FRAME_LEN = SIPM_FRAME_CYC,
  parameter int RAMP_CYC  = SIPM_RAMP_STEP_CYC
) (
  input  wire logic               i_clk,
  input  wire logic               i_rstn,
  input  wire logic [7:0]         i_addr,
  input  wire logic [7:0]         i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic      [7:0]         o_rdata,
  input  wire logic               i_sync_pin,
  input  wire logic               i_frame_mark,
  input  wire logic signed [15:0] i_phase_offset,
  output logic signed [15:0]      o_phase_offset,
  output logic                    o_holdover,
  output logic                    o_divider_reset,
  output logic                    o_sync_alarm,
  output logic signed [14:0]      o_align_error,
  output logic                    o_independent_frame_pulses,
  output logic                    o_line_rate_sync_sampling,
  output logic      [3:0]         o_sync_reference_source
);
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic signed [15:0] step_toward(input logic signed [15:0] cur,
                                                     input logic signed [15:0] tgt);
    if (cur < tgt) begin
      step_toward = cur + 16'sh0001;
    end else if (cur > tgt) begin
      step_toward = cur - 16'sh0001;
    end else begin
      step_toward = cur;
    end
  endfunction

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  sipm_phase_cfg_t    phase_cfg;
  sipm_phase_cfg_t    next_phase_cfg;
  sipm_mon_cfg_t      mon_cfg;
  sipm_mon_cfg_t      next_mon_cfg;
  sipm_cal_state_t    cal_state;
  sipm_cal_state_t    next_cal_state;
  logic        [7:0]  next_rdata;
  logic signed [15:0] next_offset;
  logic signed [15:0] target;
  logic        [15:0] tick_cnt;
  logic        [15:0] next_tick_cnt;
  logic               tick;
  logic               next_div_reset;
  logic               sync_s1;
  logic               sync_s2;
  logic               sync_s3;
  logic               sync_lvl;
  logic               sync_lvl_q;
  logic               next_sync_lvl;
  logic               sync_edge;
  logic               wr_phase;
  logic               wr_mon;
  logic               cal_start;
  logic               cal_busy;

  // ------------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------------
  assign wr_phase  = i_wr && (i_addr == SIPM_ADDR_PHASE);
  assign wr_mon    = i_wr && (i_addr == SIPM_ADDR_MON);
  assign cal_busy  = (cal_state != SIPM_CAL_IDLE);
  assign cal_start = wr_mon && i_wdata[SIPM_MON_CAL_POS] && !cal_busy;

  // next configuration; bits 5:2 of the phase register are dropped
  always_comb begin
    next_phase_cfg = phase_cfg;
    next_mon_cfg   = mon_cfg;
    if (wr_phase) begin
      next_phase_cfg.independent_frame_pulses = i_wdata[SIPM_PH_INDEP_POS];
      next_phase_cfg.line_rate_sync_sampling  = i_wdata[SIPM_PH_LINE_POS];
      next_phase_cfg.sync_phase = i_wdata[SIPM_PH_PHASE_LSB +: 2];
    end
    if (wr_mon) begin
      next_mon_cfg.limit      = i_wdata[SIPM_MON_LIM_LSB +: 3];
      next_mon_cfg.ref_source = i_wdata[SIPM_MON_SRC_LSB +: 4];
    end
  end

  // ------------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------------
  // read data is captured on the read strobe and held afterwards
  always_comb begin
    next_rdata = o_rdata;
    if (i_rd) begin
      unique case (i_addr)
        SIPM_ADDR_PHASE: next_rdata = {phase_cfg.independent_frame_pulses,
                                       phase_cfg.line_rate_sync_sampling,
                                       4'h0, phase_cfg.sync_phase};
        SIPM_ADDR_MON:   next_rdata = {cal_busy, mon_cfg.limit, mon_cfg.ref_source};
        default:         next_rdata = 8'h00;
      endcase
    end
  end

  // configuration and read registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      phase_cfg <= sipm_phase_cfg_t'(SIPM_PHASE_RST);
      mon_cfg   <= sipm_mon_cfg_t'(SIPM_MON_RST[6:0]);
      o_rdata   <= 8'h00;
    end else begin
      phase_cfg <= next_phase_cfg;
      mon_cfg   <= next_mon_cfg;
      o_rdata   <= next_rdata;
    end
  end

  // ------------------------------------------------------------------
  // sync input sampling
  // ------------------------------------------------------------------
  // level accepted once the second and third stage agree
  always_comb begin
    next_sync_lvl = (sync_s2 == sync_s3) ? sync_s3 : sync_lvl;
  end
  assign sync_edge = sync_lvl && !sync_lvl_q;

  // synchroniser chain
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync_s1    <= 1'b0;
      sync_s2    <= 1'b0;
      sync_s3    <= 1'b0;
      sync_lvl   <= 1'b0;
      sync_lvl_q <= 1'b0;
    end else begin
      sync_s1    <= i_sync_pin;
      sync_s2    <= sync_s1;
      sync_s3    <= sync_s2;
      sync_lvl   <= next_sync_lvl;
      sync_lvl_q <= sync_lvl;
    end
  end

  // monitor compares the edge with the output frame, no realignment
  sipm_align_check #(
    .FRAME_LEN (FRAME_LEN)
  ) sipm_align_check_inst (
    .i_clk        (i_clk),
    .i_rstn       (i_rstn),
    .i_frame_mark (i_frame_mark),
    .i_sync_edge  (sync_edge),
    .i_sync_phase (phase_cfg.sync_phase),
    .i_limit      (mon_cfg.limit),
    .o_alarm      (o_sync_alarm),
    .o_error      (o_align_error)
  );

  // ------------------------------------------------------------------
  // phase offset ramp and calibration
  // ------------------------------------------------------------------
  assign tick   = (32'(tick_cnt) == RAMP_CYC - 1);
  assign target = (cal_state == SIPM_CAL_TO_ZERO || cal_state == SIPM_CAL_DIV_RST)
                  ? 16'sh0000 : i_phase_offset;

  // ramp walks one step per tick; calibration sequences through its phases
  always_comb begin
    next_tick_cnt  = tick ? 16'h0000 : tick_cnt + 16'h0001;
    next_offset    = tick ? step_toward(o_phase_offset, target) : o_phase_offset;
    next_cal_state = cal_state;
    next_div_reset = 1'b0;
    unique case (cal_state)
      SIPM_CAL_IDLE: begin
        if (cal_start) begin
          next_cal_state = SIPM_CAL_TO_ZERO;
        end
      end
      SIPM_CAL_TO_ZERO: begin
        if (o_phase_offset == 16'sh0000) begin
          next_cal_state = SIPM_CAL_DIV_RST;
          next_div_reset = 1'b1;
        end
      end
      SIPM_CAL_DIV_RST: begin
        next_cal_state = SIPM_CAL_TO_PROG;
      end
      SIPM_CAL_TO_PROG: begin
        if (o_phase_offset == i_phase_offset) begin
          next_cal_state = SIPM_CAL_IDLE;
        end
      end
    endcase
  end

  // ramp and calibration registers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_cnt        <= 16'h0000;
      o_phase_offset  <= 16'sh0000;
      cal_state       <= SIPM_CAL_IDLE;
      o_divider_reset <= 1'b0;
    end else begin
      tick_cnt        <= next_tick_cnt;
      o_phase_offset  <= next_offset;
      cal_state       <= next_cal_state;
      o_divider_reset <= next_div_reset;
    end
  end

  assign o_holdover                 = cal_busy;
  assign o_independent_frame_pulses = phase_cfg.independent_frame_pulses;
  assign o_line_rate_sync_sampling  = phase_cfg.line_rate_sync_sampling;
  assign o_sync_reference_source    = mon_cfg.ref_source;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  ramp_step_size_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (o_phase_offset - $past(o_phase_offset) <= 16'sh0001) &&
    ($past(o_phase_offset) - o_phase_offset <= 16'sh0001))
    else $error("phase offset jumped");
  cal_launch_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    cal_start |=> cal_state == SIPM_CAL_TO_ZERO)
    else $error("calibration not launched");
  cal_clear_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    cal_state == SIPM_CAL_TO_PROG && o_phase_offset == i_phase_offset |=> !cal_busy)
    else $error("calibrate bit did not clear");
  div_reset_zero_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_divider_reset |-> o_phase_offset == 16'sh0000 && o_holdover)
    else $error("divider reset outside zero offset holdover");
  div_reset_once_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_divider_reset |=> !o_divider_reset)
    else $error("divider reset longer than one cycle");
  idle_no_reset_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !cal_busy |-> !o_divider_reset)
    else $error("divider reset while idle");
  reserved_zero_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_rd && i_addr == SIPM_ADDR_PHASE |=> o_rdata[5:2] == 4'h0)
    else $error("unused bits read nonzero");
  unmapped_zero_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_rd && i_addr != SIPM_ADDR_PHASE && i_addr != SIPM_ADDR_MON |=> o_rdata == 8'h00)
    else $error("unmapped read nonzero");
  sync_edge_lag_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    sync_edge |-> $past(sync_s3) && $past(sync_s2))
    else $error("sync edge without agreeing stages");
  cover_cal_c: cover property (@(posedge i_clk) disable iff (!i_rstn) $fell(cal_busy));
  cover_ramp_c: cover property (@(posedge i_clk) disable iff (!i_rstn)
    !cal_busy && tick && o_phase_offset != i_phase_offset);
  cover_sync_c: cover property (@(posedge i_clk) disable iff (!i_rstn) sync_edge);
endmodule

// *** verif/sipm_sync_source.sv ***
// behavioural external frame sync source and generated frame mark
`timescale 1ns/1ps
module sipm_sync_source #(
  parameter int FRAME_LEN = 40
) (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic [7:0] i_pos,
  output logic            o_frame_mark,
  output logic            o_sync_pin
);
  logic [7:0] fc;
  logic [7:0] rel;
  // position of the frame count relative to the programmed sync position
  assign rel = (fc >= i_pos) ? fc - i_pos : fc + 8'(FRAME_LEN) - i_pos;
  assign o_frame_mark = (fc == 8'h00);
  assign o_sync_pin = (rel < 8'h04); // wide enough to pass the pin synchroniser
  // free running frame counter
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fc <= 8'h00;
    end else begin
      fc <= (fc == 8'(FRAME_LEN - 1)) ? 8'h00 : fc + 8'h01;
    end
  end
endmodule

// *** verif/test_sync_input_phase_monitor.sv ***
// self-checking bench for the sync input phase monitor
`timescale 1ns/1ps
module test_sync_input_phase_monitor;
  import sipm_pkg::*;
  localparam int LEN  = 40;
  localparam int RAMP = 2;
  localparam int LAT  = 3; // pin rise to counted position, cycles
  logic               i_clk;
  logic               i_rstn;
  logic [7:0]         i_addr;
  logic [7:0]         i_wdata;
  logic               i_wr;
  logic               i_rd;
  logic               frame_mark;
  logic               sync_pin;
  logic signed [15:0] i_phase_offset;
  logic [7:0]         o_rdata;
  logic signed [15:0] o_phase_offset;
  logic               o_holdover;
  logic               o_divider_reset;
  logic               o_sync_alarm;
  logic signed [14:0] o_align_error;
  logic               o_indep;
  logic               o_line;
  logic [3:0]         o_src;
  logic [7:0]         pos;
  logic [7:0]         exp_q[$];
  logic signed [15:0] prev;
  int                 errors;
  int                 samples_checked;
  int                 cycles;
  int                 seed;
  int                 sh2[4] = '{0, -1, 2, 1};

  sipm_top #(.FRAME_LEN(LEN), .RAMP_CYC(RAMP)) sipm_top_inst (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_sync_pin(sync_pin), .i_frame_mark(frame_mark),
    .i_phase_offset(i_phase_offset), .o_phase_offset(o_phase_offset),
    .o_holdover(o_holdover), .o_divider_reset(o_divider_reset),
    .o_sync_alarm(o_sync_alarm), .o_align_error(o_align_error),
    .o_independent_frame_pulses(o_indep), .o_line_rate_sync_sampling(o_line),
    .o_sync_reference_source(o_src));

  sipm_sync_source #(.FRAME_LEN(LEN)) sipm_sync_source_inst (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_pos(pos), .o_frame_mark(frame_mark),
    .o_sync_pin(sync_pin));

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic check(input logic signed [15:0] got, input logic signed [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #5;
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(posedge i_clk);
    #5;
    i_wr = 1'b0;
  endtask

  // the expected byte is noted before the strobe goes up
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    #5;
    exp_q.push_back(e);
    i_addr = a;
    i_rd = 1'b1;
    @(posedge i_clk);
    #5;
    i_rd = 1'b0;
  endtask

  // steps land on a free running tick, so the walk of d steps ends after more than d-1 and at most d tick periods
  task automatic ramp_to(input logic signed [15:0] tgt);
    int n;
    int d;
    n = 0;
    d = (o_phase_offset > tgt) ? int'(o_phase_offset - tgt) : int'(tgt - o_phase_offset);
    i_phase_offset = tgt;
    while (o_phase_offset !== tgt && n < 100) begin
      @(posedge i_clk);
      #5;
      n++;
    end
    check(o_phase_offset, tgt);
    check(16'(n > RAMP * (d - 1) && n <= RAMP * d), 16'h0001);
  endtask

  // sync edge placed d cycles after the frame mark
  task automatic sync_case(input logic [2:0] lim, input logic [1:0] ph, input int d,
                           input logic exp_alarm);
    wr(SIPM_ADDR_MON, {1'b0, lim, 4'hb});
    wr(SIPM_ADDR_PHASE, {6'h00, ph});
    pos = 8'((d - LAT + LEN) % LEN);
    repeat (2 * LEN) @(posedge i_clk);
    #5;
    check(16'(o_sync_alarm), 16'(exp_alarm));
  endtask

  // ------------------------------------------------------------------
  // clock, timeout and monitors
  // ------------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // read data lands on the clock edge that samples the strobe
  always @(posedge i_clk) begin
    cycles++;
    if (cycles >= 20000) begin
      errors++;
      $display("[FAIL] %0t run did not finish", $time);
      wrap_up();
    end
    if (i_rd === 1'b1) begin
      #2;
      if (exp_q.size() == 0) check(16'(o_rdata), 16'hffff);
      else check(16'(o_rdata), 16'(exp_q.pop_front()));
    end
  end

  // the applied offset never jumps by more than one step
  always @(posedge i_clk) begin
    #3;
    if (i_rstn === 1'b1 && (o_phase_offset - prev > 1 || prev - o_phase_offset > 1))
      check(o_phase_offset, prev);
    prev = o_phase_offset;
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    logic [7:0] v;
    int         n;
    int         pulses;
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    seed = 32'he860f10a;
    {i_addr, i_wdata, i_wr, i_rd, pos} = '0;
    i_phase_offset = 16'sh0000;
    prev = 16'sh0000;
    i_rstn = 1'b0;
    repeat (20) @(posedge i_clk);
    #5;
    i_rstn = 1'b1;
    rd(SIPM_ADDR_PHASE, SIPM_PHASE_RST);
    rd(SIPM_ADDR_MON, SIPM_MON_RST);
    check(16'(o_src), 16'h000b);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      wr(SIPM_ADDR_PHASE, v);
      rd(SIPM_ADDR_PHASE, v & 8'hc3);
      check(16'({o_indep, o_line}), 16'(v[7:6]));
      v = 8'($random(seed)) & 8'h7f;
      wr(SIPM_ADDR_MON, v);
      rd(SIPM_ADDR_MON, v);
    end
    wr(8'h7d, 8'hff);
    rd(8'h7d, 8'h00);
    for (int l = 0; l < 8; l++) begin
      sync_case(3'(l), SIPM_PHASE_ON_TARGET, -l - 1, 1'b0);
      sync_case(3'(l), SIPM_PHASE_ON_TARGET, l + 2, 1'b1);
    end
    for (int p = 0; p < 4; p++) begin
      sync_case(3'h2, 2'(p), 2, 1'b0);
      check(16'(o_align_error), 16'(4 - sh2[p]));
      repeat (LEN) @(posedge i_clk);
      #5;
      check(16'(o_align_error), 16'(4 - sh2[p]));
    end
    ramp_to(16'sd3);
    wr(SIPM_ADDR_MON, 8'hab);
    n = 0;
    while (o_holdover !== 1'b1 && n < 3) begin
      @(posedge i_clk);
      #5;
      n++;
    end
    check(16'(o_holdover), 16'h0001);
    rd(SIPM_ADDR_MON, 8'hab);
    wr(SIPM_ADDR_MON, 8'hab);
    pulses = 0;
    n = 0;
    while (o_holdover === 1'b1 && n < 300) begin
      if (o_divider_reset === 1'b1) begin
        pulses++;
        check(o_phase_offset, 16'sd0);
      end
      @(posedge i_clk);
      #5;
      n++;
    end
    check(16'(o_holdover), 16'h0000);
    check(16'(pulses), 16'h0001);
    check(o_phase_offset, 16'sd3);
    rd(SIPM_ADDR_MON, 8'h2b);
    ramp_to(-16'sd2);
    repeat (4) @(posedge i_clk);
    wrap_up();
  end
endmodule
